// ### rtl/energy_detect_channel_assess.sv
// Energy-detection result register and clear-channel-assessment engine.
`timescale 1ns/1ps
module energy_detect_channel_assess
   import ed_cca_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [4:0] rssi_value,
   input wire logic carrier_sense,
   input wire logic rx_listen,
   input wire logic rx_busy,
   input wire logic basic_mode,
   input wire logic high_rate,
   input wire logic auto_ed_trigger,
   input wire logic [4:0] radio_state,
   output logic assess_energy_done_event
);
   import ed_cca_pkg::*;

   ed_meas_if meas_if ();

   ed_averager u_averager (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .rssi_value(rssi_value),
      .meas(meas_if.meas)
   );

   assess_state_e state;
   assess_state_e next_state;
   logic [7:0] energy_level_result;
   logic [1:0] assess_mode_field;
   logic [4:0] channel;
   logic [7:0] energy_threshold_config;
   logic assess_complete_flag;
   logic channel_idle_flag;
   logic auto_run;
   logic auto_taken;
   logic cs_seen;
   logic wait_is_cca;
   logic next_wait_is_cca;
   logic ed_req;
   logic cca_req;
   logic in_rx;
   logic auto_start;
   logic manual_start;
   logic energy_busy;
   logic meas_energy_busy;
   logic cca_finish;
   logic cca_idle_value;
   logic ed_finish;
   logic cca_eval_now;
   logic [1:0] req_mode;

   // Busy decision per mode from an energy verdict and a carrier verdict.
   function automatic logic channel_busy(input logic [1:0] mode, input logic eb,
                                         input logic cs);
      logic b;
      b = 1'b0;
      case (mode)
         CCA_ED: b = eb;
         CCA_CS: b = cs;
         CCA_CS_OR_ED: b = cs | eb;
         CCA_CS_AND_ED: b = cs & eb;
         default: b = 1'b0;
      endcase
      return b;
   endfunction

   assign ed_req = reg_wr && (reg_addr == ADDR_ENERGY_LEVEL_RESULT);
   assign cca_req = reg_wr && (reg_addr == ADDR_CCA_CTRL) && reg_wdata[REQ_BIT];
   assign in_rx = rx_listen | rx_busy;

   // Only one automatic measurement per frame; the flag drops with the frame.
   assign auto_start = auto_ed_trigger && rx_busy && !auto_taken;

   // Threshold compare against twice the field, both in 1 dB units above base.
   assign energy_busy = energy_level_result > {3'h0, energy_threshold_config[THRES_MSB:0], 1'b0};
   assign meas_energy_busy = meas_if.level > {3'h0, energy_threshold_config[THRES_MSB:0], 1'b0};

   // Manual measurements are always long: keeps 128 us while listening.
   assign manual_start = (state == ST_IDLE) && rx_listen && !auto_start
                         && (ed_req || (cca_req && basic_mode));
   assign meas_if.start = auto_start | manual_start;
   assign meas_if.long_win = manual_start ? 1'b1 : !high_rate;

   // A request carries its own mode; the stored field only lands on the next edge.
   assign req_mode = (reg_wr && (reg_addr == ADDR_CCA_CTRL)) ? reg_wdata[MODE_MSB:MODE_LSB]
                     : assess_mode_field;

   // Assessment while busy receiving can be answered from the stored result.
   assign cca_eval_now = rx_busy && basic_mode
                         && ((req_mode == CCA_CS) || !auto_run);

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         auto_taken <= 1'b0;
         auto_run <= 1'b0;
      end else begin
         if (!rx_busy) begin
            auto_taken <= 1'b0;
         end else if (auto_start) begin
            auto_taken <= 1'b1;
         end
         if (auto_start) begin
            auto_run <= 1'b1;
         end else if (meas_if.done) begin
            auto_run <= 1'b0;
         end
      end
   end

   // Carrier activity is gathered over the whole listening window.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cs_seen <= 1'b0;
      end else if (manual_start) begin
         cs_seen <= carrier_sense;
      end else if (state == ST_CCA) begin
         cs_seen <= cs_seen | carrier_sense;
      end
   end

   // Completion decode for this cycle.
   always_comb begin
      next_state = state;
      next_wait_is_cca = wait_is_cca;
      cca_finish = 1'b0;
      cca_idle_value = 1'b0;
      ed_finish = 1'b0;
      case (state)
         ST_IDLE: begin
            if (cca_req) begin
               if (!(basic_mode && in_rx)) begin
                  cca_finish = 1'b1;
               end else if (rx_listen && !auto_start) begin
                  next_state = ST_CCA;
               end else if (cca_eval_now) begin
                  cca_finish = 1'b1;
                  cca_idle_value = !channel_busy(req_mode, energy_busy,
                                                 carrier_sense);
               end else begin
                  next_state = ST_WAIT_AUTO;
                  next_wait_is_cca = 1'b1;
               end
            end else if (ed_req) begin
               if (rx_listen && !auto_start) begin
                  next_state = ST_ED;
               end else if (rx_busy && (auto_run || auto_start)) begin
                  next_state = ST_WAIT_AUTO;
                  next_wait_is_cca = 1'b0;
               end else begin
                  ed_finish = 1'b1;
               end
            end
         end
         ST_ED: begin
            if (meas_if.done) begin
               ed_finish = 1'b1;
               next_state = ST_IDLE;
            end
         end
         ST_CCA: begin
            if (meas_if.done) begin
               cca_finish = 1'b1;
               cca_idle_value = !channel_busy(assess_mode_field, meas_energy_busy,
                                              cs_seen | carrier_sense);
               next_state = ST_IDLE;
            end
         end
         ST_WAIT_AUTO: begin
            if (meas_if.done || !rx_busy) begin
               next_state = ST_IDLE;
               if (wait_is_cca) begin
                  cca_finish = 1'b1;
                  cca_idle_value = meas_if.done
                     && !channel_busy(assess_mode_field, meas_energy_busy, carrier_sense);
               end else begin
                  ed_finish = 1'b1;
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         wait_is_cca <= 1'b0;
      end else begin
         state <= next_state;
         wait_is_cca <= next_wait_is_cca;
      end
   end

   // The result only moves when a measurement really ran.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         energy_level_result <= ENERGY_LEVEL_RESULT_RESET;
      end else if (meas_if.done) begin
         energy_level_result <= meas_if.level;
      end
   end

   // Completion wins over a request landing in the same cycle.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         assess_complete_flag <= 1'b0;
         channel_idle_flag <= 1'b0;
      end else if (cca_finish) begin
         assess_complete_flag <= 1'b1;
         channel_idle_flag <= cca_idle_value;
      end else if (cca_req) begin
         assess_complete_flag <= 1'b0;
         channel_idle_flag <= 1'b0;
      end
   end

   // One shared pulse for energy and assessment completion.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         assess_energy_done_event <= 1'b0;
      end else begin
         assess_energy_done_event <= cca_finish | ed_finish;
      end
   end

   // The request bit is a strobe and is never stored.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         assess_mode_field <= CCA_CTRL_RESET[MODE_MSB:MODE_LSB];
         channel <= CCA_CTRL_RESET[CHAN_MSB:0];
         energy_threshold_config <= THRES_RESET;
      end else if (reg_wr) begin
         if (reg_addr == ADDR_CCA_CTRL) begin
            assess_mode_field <= reg_wdata[MODE_MSB:MODE_LSB];
            channel <= reg_wdata[CHAN_MSB:0];
         end
         if (reg_addr == ADDR_THRES) begin
            energy_threshold_config <= reg_wdata;
         end
      end
   end

   // Read data is registered one edge after the read strobe.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            ADDR_STATUS: reg_rdata <= {assess_complete_flag, channel_idle_flag, 1'b0,
                                       radio_state};
            ADDR_CCA_CTRL: reg_rdata <= {1'b0, assess_mode_field, channel};
            ADDR_THRES: reg_rdata <= energy_threshold_config;
            ADDR_ENERGY_LEVEL_RESULT: reg_rdata <= energy_level_result;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end
endmodule

// ### rtl/ed_cca_pkg.sv
// Constants, register map and mode codes for the energy-detect and channel-assessment block.
package ed_cca_pkg;

   // Register offsets on the internal register port.
   localparam logic [5:0] ADDR_STATUS = 6'h01;
   localparam logic [5:0] ADDR_CCA_CTRL = 6'h08;
   localparam logic [5:0] ADDR_THRES = 6'h09;
   localparam logic [5:0] ADDR_ENERGY_LEVEL_RESULT = 6'h07;

   // Field positions.
   localparam int DONE_BIT = 7;
   localparam int IDLE_BIT = 6;
   localparam int REQ_BIT = 7;
   localparam int MODE_LSB = 5;
   localparam int MODE_MSB = 6;
   localparam int CHAN_MSB = 4;
   localparam int THRES_MSB = 3;

   // Reset values.
   localparam logic [7:0] ENERGY_LEVEL_RESULT_RESET = 8'hff;
   localparam logic [7:0] CCA_CTRL_RESET = 8'h2b;
   localparam logic [7:0] THRES_RESET = 8'hc7;

   // Result scaling: RSSI steps are 3 dB, result steps are 1 dB, threshold steps 2 dB.
   localparam logic [7:0] ENERGY_LEVEL_RESULT_MAX = 8'h53;
   localparam logic [12:0] RSSI_STEP_DB = 13'h0003;

   // Timing.
   localparam int CLK_PERIOD_NS = 100;
   localparam int ED_LONG_NS = 128000;
   localparam int ED_SHORT_NS = 32000;
   localparam int SAMPLE_NS = 2000;
   localparam int CCA_MAX_NS = 180000;
   localparam int ED_LONG_CYC = (ED_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ED_SHORT_CYC = (ED_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CCA_MAX_CYC = CCA_MAX_NS / CLK_PERIOD_NS;
   localparam logic [4:0] SAMPLE_LAST = 5'(SAMPLE_CYC - 1);
   localparam logic [6:0] LONG_LAST = 7'(ED_LONG_CYC / SAMPLE_CYC - 1);
   localparam logic [6:0] SHORT_LAST = 7'(ED_SHORT_CYC / SAMPLE_CYC - 1);
   localparam int LONG_SHIFT = $clog2(ED_LONG_CYC / SAMPLE_CYC);
   localparam int SHORT_SHIFT = $clog2(ED_SHORT_CYC / SAMPLE_CYC);

   typedef enum logic [1:0] {
      CCA_CS_OR_ED = 2'h0,
      CCA_ED = 2'h1,
      CCA_CS = 2'h2,
      CCA_CS_AND_ED = 2'h3
   } assess_mode_field_e;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_ED = 4'h2,
      ST_CCA = 4'h4,
      ST_WAIT_AUTO = 4'h8
   } assess_state_e;

endpackage

// ### rtl/ed_meas_if.sv
// Start and result signals between the assessment engine and the energy averager.
`timescale 1ns/1ps
interface ed_meas_if;
   logic start;
   logic long_win;
   logic done;
   logic [7:0] level;
   modport ctrl (output start, output long_win, input done, input level);
   modport meas (input start, input long_win, output done, output level);
endinterface

// ### rtl/ed_averager.sv
// Averages signal-strength samples over a measurement window into a 1 dB energy level.
`timescale 1ns/1ps
module ed_averager
   import ed_cca_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [4:0] rssi_value,
   ed_meas_if.meas meas
);
   logic run;
   logic long_q;
   logic [4:0] tick;
   logic [6:0] samples;
   logic [10:0] sum;
   logic [10:0] next_sum;
   logic [12:0] scaled;
   logic [12:0] shifted;
   logic last_tick;
   logic last_sample;

   assign next_sum = sum + {6'h00, rssi_value};
   assign scaled = 13'(next_sum) * RSSI_STEP_DB;
   assign shifted = long_q ? (scaled >> LONG_SHIFT) : (scaled >> SHORT_SHIFT);
   assign last_tick = run && (tick == SAMPLE_LAST);
   assign last_sample = samples == (long_q ? LONG_LAST : SHORT_LAST);

   // A new start restarts the window even mid-measurement.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         run <= 1'b0;
         long_q <= 1'b1;
         tick <= 5'h00;
         samples <= 7'h00;
         sum <= 11'h000;
      end else if (meas.start) begin
         run <= 1'b1;
         long_q <= meas.long_win;
         tick <= 5'h00;
         samples <= 7'h00;
         sum <= 11'h000;
      end else if (last_tick) begin
         tick <= 5'h00;
         sum <= next_sum;
         samples <= samples + 7'h01;
         if (last_sample) begin
            run <= 1'b0;
         end
      end else if (run) begin
         tick <= tick + 5'h01;
      end
   end

   // Zero means at or below the base level; full scale clamps to the top code.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         meas.done <= 1'b0;
         meas.level <= 8'h00;
      end else begin
         meas.done <= last_tick && last_sample && !meas.start;
         if (last_tick && last_sample) begin
            meas.level <= (shifted > 13'(ENERGY_LEVEL_RESULT_MAX)) ? ENERGY_LEVEL_RESULT_MAX : shifted[7:0];
         end
      end
   end
endmodule

// ### verification/ed_cca_props.sv
// Port-level assertions for the energy-detect and channel-assessment block.
`timescale 1ns/1ps
module ed_cca_props
   import ed_cca_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [4:0] rssi_value,
   input wire logic carrier_sense,
   input wire logic rx_listen,
   input wire logic rx_busy,
   input wire logic basic_mode,
   input wire logic high_rate,
   input wire logic auto_ed_trigger,
   input wire logic [4:0] radio_state,
   input wire logic assess_energy_done_event
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   logic req;
   // Both ways of asking for a measurement count, since the engine treats them alike when listening in basic mode or outside receive.
   assign req = reg_wr && (reg_addr == ADDR_ENERGY_LEVEL_RESULT
      || (reg_addr == ADDR_CCA_CTRL && reg_wdata[REQ_BIT]));
   logic waiting;
   logic [10:0] wait_cnt;
   // The wait is far too long for a delay range, so it is counted here instead.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         waiting <= 1'b0;
         wait_cnt <= 11'h000;
      end else if (waiting && assess_energy_done_event) begin
         waiting <= 1'b0;
      end else if (waiting) begin
         wait_cnt <= wait_cnt + 11'h001;
      end else if (req && rx_listen && basic_mode) begin
         waiting <= 1'b1;
         wait_cnt <= 11'h000;
      end
   end
   reset_clear_a: assert property ($fell(sys_rst) |-> reg_rdata == 8'h00 && !assess_energy_done_event)
      else $error("read data or event not clear after reset");
   event_pulse_a: assert property (assess_energy_done_event |=> !assess_energy_done_event)
      else $error("done event longer than one cycle");
   req_reads_zero_a: assert property (reg_rd && reg_addr == ADDR_CCA_CTRL |=> !reg_rdata[REQ_BIT])
      else $error("request bit read back as one");
   ed_range_a: assert property (reg_rd && reg_addr == ADDR_ENERGY_LEVEL_RESULT |=>
      (reg_rdata <= ENERGY_LEVEL_RESULT_MAX || reg_rdata == ENERGY_LEVEL_RESULT_RESET))
      else $error("energy result out of range");
   no_rx_done_a: assert property (req && !rx_listen && !rx_busy |=> assess_energy_done_event)
      else $error("no prompt done outside receive states");
   cs_busy_fast_a: assert property (req && reg_addr == ADDR_CCA_CTRL && rx_busy && !rx_listen
      && basic_mode && reg_wdata[MODE_MSB:MODE_LSB] == CCA_CS |=> assess_energy_done_event)
      else $error("carrier-only result not immediate while receiving");
   listen_time_a: assert property (waiting |-> wait_cnt < 11'(CCA_MAX_CYC))
      else $error("listening measurement not done in time");
   listen_early_a: assert property (waiting && wait_cnt < 11'h008 |-> !assess_energy_done_event)
      else $error("listening measurement done too early");
   rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");
endmodule

// ### verification/host_model.sv
// Host model: single write and read cycles on the register port.
`timescale 1ns/1ps
module host_model (
   input wire logic mclk,
   output logic [5:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 6'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // Address and data are inverted when released, so a stale value cannot pass unnoticed.
   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      @(posedge mclk);
      #1;
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(posedge mclk);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~v;
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] v);
      @(posedge mclk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge mclk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      v = reg_rdata;
   endtask
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the energy-detect and channel-assessment block.
`timescale 1ns/1ps
module tb_top;
   import ed_cca_pkg::*;
   logic mclk, sys_rst, reg_wr, reg_rd, carrier_sense, rx_listen, rx_busy;
   logic basic_mode, high_rate, auto_ed_trigger, ev;
   logic [5:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d;
   logic [4:0] rssi_value, radio_state;
   int failures, n_checks, n;
   logic [4:0] ed_rssi [3] = '{5'h00, 5'h0a, 5'h1c};
   logic [7:0] ed_exp [3] = '{8'h00, 8'h1e, 8'h53};
   logic [1:0] m_tab [8] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h0, 2'h3, 2'h3};
   logic [4:0] rs_tab [8] = '{5'h03, 5'h04, 5'h1c, 5'h00, 5'h04, 5'h00, 5'h03, 5'h04};
   logic [7:0] cs_tab = 8'he8;
   logic [7:0] id_tab = 8'h45;
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   host_model host_model_i (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   energy_detect_channel_assess energy_detect_channel_assess_i (.mclk(mclk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .rssi_value(rssi_value), .carrier_sense(carrier_sense),
      .rx_listen(rx_listen), .rx_busy(rx_busy), .basic_mode(basic_mode), .high_rate(high_rate),
      .auto_ed_trigger(auto_ed_trigger), .radio_state(radio_state),
      .assess_energy_done_event(ev));
   task automatic print_verdict;
      if (failures == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("mismatch %s exp %h got %h", name, exp, got);
         failures++;
      end
   endtask
   task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp, input string name);
      host_model_i.rd(a, d);
      chk(name, exp, d);
   endtask
   // The event stands one cycle only, so it is sampled after every edge.
   task automatic wait_done(input int lo, input int hi);
      n = 0;
      while (ev !== 1'b1) begin
         if (n >= hi) begin
            $display("mismatch done_wait exp %0d got timeout", hi);
            failures++;
            print_verdict();
         end
         @(posedge mclk);
         #1;
         n++;
      end
      n_checks++;
      if (n < lo) begin
         $display("mismatch done_time exp %0d got %0d", lo, n);
         failures++;
      end
   endtask
   task automatic assess(input logic [1:0] m, input logic idle, input int lo, input int hi);
      host_model_i.wr(ADDR_CCA_CTRL, {1'b1, m, 5'h0b});
      if (hi > 10) begin
         rd_chk(ADDR_STATUS, {3'b000, radio_state}, "status_cleared");
      end
      wait_done(lo, hi);
      rd_chk(ADDR_STATUS, {1'b1, idle, 1'b0, radio_state}, "status");
      rd_chk(ADDR_CCA_CTRL, {1'b0, m, 5'h0b}, "ctrl");
   endtask
   initial begin
      failures = 0;
      n_checks = 0;
      sys_rst = 1'b1;
      rssi_value = 5'h00;
      carrier_sense = 1'b0;
      rx_listen = 1'b1;
      rx_busy = 1'b0;
      basic_mode = 1'b1;
      high_rate = 1'b0;
      auto_ed_trigger = 1'b0;
      radio_state = 5'h06;
      repeat (5) @(posedge mclk);
      #1;
      sys_rst = 1'b0;
      rd_chk(ADDR_ENERGY_LEVEL_RESULT, ENERGY_LEVEL_RESULT_RESET, "ed_reset");
      rd_chk(ADDR_CCA_CTRL, CCA_CTRL_RESET, "ctrl_reset");
      rd_chk(ADDR_THRES, THRES_RESET, "thres_reset");
      rd_chk(ADDR_STATUS, {3'b000, radio_state}, "status_reset");
      rd_chk(6'h3f, 8'h00, "unmapped");
      for (int i = 0; i < 3; i++) begin
         rssi_value = ed_rssi[i];
         host_model_i.wr(ADDR_ENERGY_LEVEL_RESULT, 8'h5a);
         wait_done(1270, 1800);
         rd_chk(ADDR_ENERGY_LEVEL_RESULT, ed_exp[i], "energy_level_result");
      end
      host_model_i.wr(ADDR_THRES, 8'hc5);
      rd_chk(ADDR_THRES, 8'hc5, "thres");
      for (int i = 0; i < 8; i++) begin
         rssi_value = rs_tab[i];
         carrier_sense = cs_tab[i];
         assess(m_tab[i], id_tab[i], 1270, 1800);
      end
      rx_listen = 1'b0;
      assess(2'h1, 1'b0, 0, 2);
      rx_listen = 1'b1;
      basic_mode = 1'b0;
      assess(2'h1, 1'b0, 0, 2);
      basic_mode = 1'b1;
      rx_listen = 1'b0;
      rx_busy = 1'b1;
      assess(2'h2, 1'b0, 0, 2);
      high_rate = 1'b1;
      rssi_value = 5'h0a;
      carrier_sense = 1'b0;
      @(posedge mclk);
      #1;
      auto_ed_trigger = 1'b1;
      @(posedge mclk);
      #1;
      auto_ed_trigger = 1'b0;
      assess(2'h1, 1'b0, 200, 330);
      assess(2'h1, 1'b0, 0, 2);
      rd_chk(ADDR_ENERGY_LEVEL_RESULT, 8'h1e, "ed_auto");
      rx_busy = 1'b0;
      rx_listen = 1'b1;
      host_model_i.wr(ADDR_ENERGY_LEVEL_RESULT, 8'h00);
      wait_done(1270, 1800);
      print_verdict();
   end
endmodule
bind energy_detect_channel_assess ed_cca_props ed_cca_props_i (.mclk(mclk), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .rssi_value(rssi_value), .carrier_sense(carrier_sense),
   .rx_listen(rx_listen), .rx_busy(rx_busy), .basic_mode(basic_mode), .high_rate(high_rate),
   .auto_ed_trigger(auto_ed_trigger), .radio_state(radio_state),
   .assess_energy_done_event(assess_energy_done_event));
